/* File: hdl/rxrc_consts.svh */
// Register offset, field positions and reset values of the receive read configuration
`ifndef RXRC_CONSTS_SVH
`define RXRC_CONSTS_SVH
`define RXRC_ADDR_W        8
`define RXRC_CFG_OFFSET    8'h6c
`define RXRC_EA_HI         31
`define RXRC_EA_LO         30
`define RXRC_CNT_HI        27
`define RXRC_CNT_LO        16
`define RXRC_FLUSH_BIT     15
`define RXRC_OFF_HI        12
`define RXRC_OFF_LO        8
`define RXRC_OFF_DW_LO     10
`define RXRC_CNT_W         12
`define RXRC_OFF_W         5
`define RXRC_EA_RST        2'h0
`define RXRC_CNT_RST       12'h000
`define RXRC_OFF_RST       5'h00
`define RXRC_CNT_ONE       12'h001
`define RXRC_PAD_CNT_W     3
`define RXRC_PAD_NONE      3'h0
`define RXRC_PAD_ONE       3'h1
`define RXRC_POS_MASK_16B  3'h3
`define RXRC_POS_MASK_32B  3'h7
`endif

/* File: hdl/rxrc_pkg.sv */
// Types for the receive read configuration block
package rxrc_pkg;
  typedef enum logic [1:0] {
    RXRC_ALIGN_4B,
    RXRC_ALIGN_16B,
    RXRC_ALIGN_32B,
    RXRC_ALIGN_RSVD
  } rxrc_align_t;
  typedef enum logic {
    RXRC_ST_DATA,
    RXRC_ST_PAD
  } rxrc_state_t;
endpackage

/* File: hdl/rxrc_pad_unit.sv */
// End-of-buffer padding sequencer for receive data reads
`timescale 1ns/1ns
`include "rxrc_consts.svh"
module rxrc_pad_unit
  import rxrc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [1:0]  align_i,
  input  wire logic        last_dw_i,
  input  wire logic        read_i,
  output logic             pad_active_o,
  output logic [2:0]       pad_left_o
);
  // ----------------------------------------------------------------
  // Filler count after last data word
  // ----------------------------------------------------------------
  rxrc_state_t                   state_r;
  rxrc_state_t                   state_nxt;
  logic [`RXRC_PAD_CNT_W-1:0]    dw_pos_r;
  logic [`RXRC_PAD_CNT_W-1:0]    dw_pos_nxt;
  logic [`RXRC_PAD_CNT_W-1:0]    pad_r;
  logic [`RXRC_PAD_CNT_W-1:0]    pad_nxt;
  logic [`RXRC_PAD_CNT_W-1:0]    pos_mask;
  logic [`RXRC_PAD_CNT_W-1:0]    pos_after;
  logic [`RXRC_PAD_CNT_W-1:0]    fill_need;

  function automatic logic [`RXRC_PAD_CNT_W-1:0] align_dw(input logic [1:0] a);
    case (rxrc_align_t'(a))
      RXRC_ALIGN_16B: align_dw = `RXRC_POS_MASK_16B;
      RXRC_ALIGN_32B: align_dw = `RXRC_POS_MASK_32B;
      default:        align_dw = `RXRC_PAD_NONE;
    endcase
  endfunction

  assign pos_mask  = align_dw(align_i);
  assign pos_after = (dw_pos_r + `RXRC_PAD_ONE) & pos_mask;
  assign fill_need = (`RXRC_PAD_NONE - pos_after) & pos_mask;

  always_comb begin
    state_nxt  = state_r;
    dw_pos_nxt = dw_pos_r;
    pad_nxt    = pad_r;
    case (state_r)
      RXRC_ST_DATA: begin
        if (read_i) begin
          if (last_dw_i) begin
            dw_pos_nxt = `RXRC_PAD_NONE;
            pad_nxt    = fill_need;
            if (fill_need != `RXRC_PAD_NONE) begin
              state_nxt = RXRC_ST_PAD;
            end
          end else begin
            dw_pos_nxt = pos_after;
          end
        end
      end
      RXRC_ST_PAD: begin
        if (read_i) begin
          pad_nxt = pad_r - `RXRC_PAD_ONE;
          if (pad_r == `RXRC_PAD_ONE) begin
            state_nxt = RXRC_ST_DATA;
          end
        end
      end
      default: state_nxt = RXRC_ST_DATA;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r  <= RXRC_ST_DATA;
      dw_pos_r <= `RXRC_PAD_NONE;
      pad_r    <= `RXRC_PAD_NONE;
    end else begin
      state_r  <= state_nxt;
      dw_pos_r <= dw_pos_nxt;
      pad_r    <= pad_nxt;
    end
  end

  assign pad_active_o = (state_r == RXRC_ST_PAD);
  assign pad_left_o   = pad_r;
endmodule

/* File: hdl/rxrc_top.sv */
// Receive FIFO read configuration register and read-path control
`timescale 1ns/1ns
`include "rxrc_consts.svh"
module rxrc_top
  import rxrc_pkg::*;
(
  input  wire logic                   CLK_I,
  input  wire logic                   RESET_I,
  input  wire logic [`RXRC_ADDR_W-1:0] ADDR_I,
  input  wire logic                   WR_I,
  input  wire logic                   RD_I,
  input  wire logic [31:0]            WDATA_I,
  output logic      [31:0]            RDATA_O,
  input  wire logic                   RXD_READ_I,
  input  wire logic                   RXD_LAST_DW_I,
  input  wire logic                   RXD_INT_EN_I,
  input  wire logic                   RXD_INT_CLR_I,
  output logic                        RXD_INT_STS_O,
  output logic                        IRQ_O,
  output logic                        RX_FLUSH_O,
  output logic                        PAD_DW_O,
  output logic [1:0]                  END_ALIGN_O,
  output logic [4:0]                  LEAD_OFFSET_O,
  output logic [11:0]                 COUNT_O
);
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [1:0]              rx_end_pad_align_r;
  logic [`RXRC_CNT_W-1:0]  rx_dword_countdown_r;
  logic [`RXRC_CNT_W-1:0]  cnt_nxt;
  logic [`RXRC_OFF_W-1:0]  rx_lead_byte_offset_r;
  logic [`RXRC_OFF_W-1:0]  off_applied_r;
  logic                    flush_r;
  logic                    sts_r;
  logic                    sts_nxt;
  logic [31:0]             rdata_r;
  logic [31:0]             cfg_view;
  logic                    sel;
  logic                    wr_cfg;
  logic                    rd_cfg;
  logic                    data_read;
  logic                    pad_active;
  logic                    reach_zero;

  assign sel       = (ADDR_I == `RXRC_CFG_OFFSET);
  assign wr_cfg    = sel & WR_I;
  assign rd_cfg    = sel & RD_I;
  assign data_read = RXD_READ_I & ~pad_active;

  assign cfg_view = {rx_end_pad_align_r, 2'h0, rx_dword_countdown_r, 3'h0,
                     rx_lead_byte_offset_r, 8'h00};

  // ----------------------------------------------------------------
  // Countdown and interrupt
  // ----------------------------------------------------------------
  assign cnt_nxt = wr_cfg ? WDATA_I[`RXRC_CNT_HI:`RXRC_CNT_LO]
                 : (data_read && rx_dword_countdown_r != `RXRC_CNT_RST)
                   ? rx_dword_countdown_r - `RXRC_CNT_ONE : rx_dword_countdown_r;
  assign reach_zero = ~wr_cfg & data_read & (rx_dword_countdown_r == `RXRC_CNT_ONE);
  assign sts_nxt    = reach_zero | (sts_r & ~RXD_INT_CLR_I);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rx_dword_countdown_r <= `RXRC_CNT_RST;
      sts_r                <= 1'b0;
    end else begin
      rx_dword_countdown_r <= cnt_nxt;
      sts_r                <= sts_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Alignment, offset, flush
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rx_end_pad_align_r    <= `RXRC_EA_RST;
      rx_lead_byte_offset_r <= `RXRC_OFF_RST;
      flush_r               <= 1'b0;
    end else begin
      flush_r <= wr_cfg & WDATA_I[`RXRC_FLUSH_BIT];
      if (wr_cfg) begin
        rx_end_pad_align_r    <= WDATA_I[`RXRC_EA_HI:`RXRC_EA_LO];
        rx_lead_byte_offset_r <= WDATA_I[`RXRC_OFF_HI:`RXRC_OFF_LO];
      end
    end
  end

  // Applied offset follows register at next data read or flush
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      off_applied_r <= `RXRC_OFF_RST;
    end else if (data_read || flush_r) begin
      off_applied_r <= rx_lead_byte_offset_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_cfg) begin
      rdata_r <= cfg_view;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Padding sequencer
  // ----------------------------------------------------------------
  rxrc_pad_unit u_pad (
    .clk_i        (CLK_I),
    .reset_i      (RESET_I | flush_r),
    .align_i      (rx_end_pad_align_r),
    .last_dw_i    (RXD_LAST_DW_I),
    .read_i       (RXD_READ_I),
    .pad_active_o (pad_active),
    .pad_left_o   ()
  );

  assign RDATA_O       = rdata_r;
  assign RXD_INT_STS_O = sts_r;
  assign IRQ_O         = sts_r & RXD_INT_EN_I;
  assign RX_FLUSH_O    = flush_r;
  assign PAD_DW_O      = pad_active;
  assign END_ALIGN_O   = rx_end_pad_align_r;
  assign LEAD_OFFSET_O = off_applied_r;
  assign COUNT_O       = rx_dword_countdown_r;
endmodule

/* File: tb/rxrc_monitor.sv */
// Port assertions for the receive read configuration block
`timescale 1ns/1ns
module rxrc_monitor (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] WDATA_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        RXD_READ_I,
  input wire logic        RXD_INT_EN_I,
  input wire logic        RXD_INT_STS_O,
  input wire logic        IRQ_O,
  input wire logic        RX_FLUSH_O,
  input wire logic        PAD_DW_O,
  input wire logic [1:0]  END_ALIGN_O,
  input wire logic [11:0] COUNT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_cfg_wr;
    WR_I && ADDR_I == 8'h6c;
  endsequence
  sequence s_data_rd;
    RXD_READ_I && !PAD_DW_O && !WR_I;
  endsequence
  a_flush_pulse: assert property (s_cfg_wr ##0 WDATA_I[15] |=> RX_FLUSH_O ##1 !RX_FLUSH_O)
    else $error("flush pulse wrong");
  a_count_load: assert property (s_cfg_wr |=> COUNT_O == $past(WDATA_I[27:16]))
    else $error("count not loaded");
  a_count_dec: assert property (s_data_rd ##0 COUNT_O != 12'h000 |=> COUNT_O == $past(COUNT_O) - 12'h001)
    else $error("count not decremented");
  a_sts_set: assert property (s_data_rd ##0 COUNT_O == 12'h001 |-> ##[1:2] RXD_INT_STS_O)
    else $error("status not set");
  a_irq_gate: assert property (IRQ_O == (RXD_INT_STS_O && RXD_INT_EN_I))
    else $error("irq gating wrong");
  a_align_read: assert property (RD_I && ADDR_I == 8'h6c |=> RDATA_O[31:30] == $past(END_ALIGN_O))
    else $error("alignment read wrong");
  a_rsvd_zero: assert property (RDATA_O[29:28] == 2'h0 && RDATA_O[15:13] == 3'h0 && RDATA_O[7:0] == 8'h00)
    else $error("reserved bits set");
  a_unmapped_zero: assert property (RD_I && ADDR_I != 8'h6c |=> RDATA_O == 32'h0000_0000)
    else $error("unmapped read nonzero");
endmodule
bind rxrc_top rxrc_monitor mon_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
  .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .RXD_READ_I(RXD_READ_I), .RXD_INT_EN_I(RXD_INT_EN_I),
  .RXD_INT_STS_O(RXD_INT_STS_O), .IRQ_O(IRQ_O), .RX_FLUSH_O(RX_FLUSH_O), .PAD_DW_O(PAD_DW_O),
  .END_ALIGN_O(END_ALIGN_O), .COUNT_O(COUNT_O));

/* File: tb/rxrc_host_model.sv */
// Host reader of the receive data FIFO
`timescale 1ns/1ns
module rxrc_host_model (
  input  wire logic clk_i,
  input  wire logic pad_i,
  output logic      read_o,
  output logic      last_o
);
  initial begin
    read_o = 1'b0;
    last_o = 1'b0;
  end
  task automatic pulse(input logic lst);
    @(posedge clk_i);
    #1 read_o = 1'b1;
    last_o = lst;
    @(posedge clk_i);
    #1 read_o = 1'b0;
    last_o = 1'b0;
  endtask
  // Reads n data DWORDs, then drains and drops filler
  task automatic read_buf(input int n, output int fillers);
    fillers = 0;
    for (int i = 1; i <= n; i++) pulse(i == n);
    while (pad_i === 1'b1 && fillers < 16) begin
      pulse(1'b0);
      fillers++;
    end
  endtask
endmodule

/* File: tb/rxrc_top_tb.sv */
// Self-checking bench for the receive read configuration block
`timescale 1ns/1ns
module rxrc_top_tb;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, en = 0, clr = 0;
  logic [7:0]  addr = 8'h6c;
  logic [31:0] wd = 0, rdat;
  logic        rxr, rxl, sts, irq, fl, pad;
  logic [1:0]  ea;
  logic [4:0]  off;
  logic [11:0] cnt;
  int          failures = 0, tests_run = 0, nf;
  int          exp_f [4] = '{0, 1, 5, 0};
  always #2 clk = ~clk;
  rxrc_top dut_u (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .WDATA_I(wd), .RDATA_O(rdat),
    .RXD_READ_I(rxr), .RXD_LAST_DW_I(rxl), .RXD_INT_EN_I(en), .RXD_INT_CLR_I(clr), .RXD_INT_STS_O(sts),
    .IRQ_O(irq), .RX_FLUSH_O(fl), .PAD_DW_O(pad), .END_ALIGN_O(ea), .LEAD_OFFSET_O(off), .COUNT_O(cnt));
  rxrc_host_model host_u (.clk_i(clk), .pad_i(pad), .read_o(rxr), .last_o(rxl));
  // ----
  // Tasks
  // ----
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("Error %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 wr = 1;
    addr = a;
    wd = d;
    tick();
    wr = 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    #1 rd = 1;
    addr = a;
    tick();
    rd = 0;
    chk(rdat, e, nm);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    rd_chk(8'h6c, 32'h0, "reset");
    wr_reg(8'h70, 32'hffff_ffff);
    rd_chk(8'h70, 32'h0, "unmapped");
    wr_reg(8'h6c, 32'h7003_0cff);
    rd_chk(8'h6c, 32'h4003_0c00, "config");
    chk(off, 5'h00, "offset early");
    en = 1;
    host_u.read_buf(3, nf);
    chk(32'(nf), 32'h1, "fillers");
    chk(off, 5'h0c, "offset");
    chk({sts, irq}, 2'b11, "interrupt");
    en = 0;
    tick();
    chk({sts, irq}, 2'b10, "masked");
    clr = 1;
    tick();
    clr = 0;
    chk(sts, 1'b0, "cleared");
    wr_reg(8'h6c, 32'h0005_0000);
    host_u.pulse(1'b0);
    chk(cnt, 12'h004, "decrement");
    wr_reg(8'h6c, 32'h0002_0000);
    chk(cnt, 12'h002, "reload");
    host_u.pulse(1'b0);
    chk(cnt, 12'h001, "reload count");
    wr_reg(8'h6c, 32'h0000_8000);
    chk(fl, 1'b1, "flush");
    tick();
    chk(fl, 1'b0, "flush end");
    rd_chk(8'h6c, 32'h0, "flush bit");
    for (int a = 0; a < 4; a++) begin
      wr_reg(8'h6c, {a[1:0], 30'h0000_8000});
      chk(ea, a[1:0], "align");
      host_u.read_buf(3, nf);
      chk(32'(nf), 32'(exp_f[a]), "pad count");
    end
    give_verdict();
  end
  initial begin
    #8000;
    failures++;
    give_verdict();
  end
endmodule
